// ### scs_cfg.svh
// timing counts, code constants and mode encodings for the conversion sequencer
`ifndef SCS_CFG_SVH
`define SCS_CFG_SVH
`define SCS_CLK_MHZ 125
`define SCS_RES_BITS 18
`define SCS_CONV_RATE_SPS 1250000
`define SCS_CONV_BUDGET_CYC ((`SCS_CLK_MHZ * 1000000) / `SCS_CONV_RATE_SPS)
`define SCS_APERTURE_NS 8
`define SCS_APERTURE_CYC ((`SCS_APERTURE_NS * `SCS_CLK_MHZ + 999) / 1000)
`define SCS_ACQ_NS 350
`define SCS_ACQ_CYC ((`SCS_ACQ_NS * `SCS_CLK_MHZ + 999) / 1000)
`define SCS_CODE_MID_SB 18'h20000
`define SCS_CODE_MID_TC 18'h00000
`define SCS_CODE_TOP_SB 18'h3ffff
`define SCS_CODE_TOP_TC 18'h1ffff
`define SCS_CODE_BOT_SB 18'h00000
`define SCS_CODE_BOT_TC 18'h20000
`define SCS_MODE_PAR18 2'h0
`define SCS_MODE_SERIAL 2'h3
`endif

// ### scs_pkg.sv
// types shared by the conversion sequencer files
`default_nettype none
package scs_pkg;
  typedef enum logic [2:0] {
    SCS_ACQ = 3'h0,
    SCS_READY = 3'h1,
    SCS_HOLD = 3'h3,
    SCS_GND = 3'h2,
    SCS_TRIAL = 3'h6,
    SCS_CODE = 3'h7
  } scs_state_type;
endpackage : scs_pkg
`default_nettype wire

// ### scs_coder.sv
// output coder: sb/tc selection with saturation, registered result
`timescale 1ns/100ps
`default_nettype none
`include "scs_cfg.svh"
module scs_coder
  import scs_pkg::*;
#(
  parameter int WIDTH = `SCS_RES_BITS
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_load,
  input wire logic [WIDTH-1:0] i_raw,
  input wire logic i_over,
  input wire logic i_under,
  input wire logic i_tc_sel,
  output logic [WIDTH-1:0] o_code
);
  ////////////////////////////////////////////////////////////////
  // saturate then flip msb for twos complement
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_code <= '0;
    end else if (i_ce && i_load) begin
      if (i_over) begin
        o_code <= i_tc_sel ? `SCS_CODE_TOP_TC : `SCS_CODE_TOP_SB; // RULE_12
      end else if (i_under) begin
        o_code <= i_tc_sel ? `SCS_CODE_BOT_TC : `SCS_CODE_BOT_SB; // RULE_13
      end else begin
        o_code <= {i_raw[WIDTH-1] ^ i_tc_sel, i_raw[WIDTH-2:0]}; // RULE_11
      end
    end
  end
endmodule : scs_coder
`default_nettype wire

// ### scs_sequencer.sv
// conversion sequencer: acquisition, sample hold, sar trials and result coding
// Operation
// (RULE_01) in acquisition both arrays connect to the inputs and track the signal
// (RULE_02) conversion starts only after acquisition and on a falling start strobe
// (RULE_03) sample freezes a fixed aperture delay after the falling start edge
// (RULE_04) open sample switches first, then tie arrays to reference ground
// (RULE_05) resolve msb first with binary-weighted trials over all bits
// (RULE_06) after all trials form the code, then drop busy
// (RULE_07) no pipeline delay: each result belongs to the latest sample
// (RULE_08) support 1.25 msps, each conversion giving an 18-bit result
// (RULE_09) coding select picks straight binary or twos complement
// (RULE_10) coding select ignored in 18-bit parallel mode
// (RULE_11) midscale 0x20000 binary, 0x00000 twos; twos is msb inverted
// (RULE_12) overrange saturates at 0x3ffff binary, 0x1ffff twos
// (RULE_13) underrange saturates at 0x00000 binary, 0x20000 twos
// (RULE_14) host selects bus mode: 00 parallel 18-bit, 11 serial
// (RULE_15) host reads after busy falls and never starts while busy
`timescale 1ns/100ps
`default_nettype none
`include "scs_cfg.svh"
module scs_sequencer
  import scs_pkg::*;
#(
  parameter int WIDTH = `SCS_RES_BITS,
  parameter int APERTURE_CYC = `SCS_APERTURE_CYC,
  parameter int ACQ_CYC = `SCS_ACQ_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_conversion_start_n,
  input wire logic i_output_coding_select,
  input wire logic i_bus_mode_sel_hi,
  input wire logic i_bus_mode_sel_lo,
  input wire logic i_comp_high,
  input wire logic i_over,
  input wire logic i_under,
  output logic o_sample_switch_pos,
  output logic o_sample_switch_neg,
  output logic o_array_to_input,
  output logic o_array_to_reference_ground,
  output logic [WIDTH-1:0] o_dac_bits,
  output logic o_busy,
  output logic [WIDTH-1:0] o_code
);
  ////////////////////////////////////////////////////////////////
  // declarations
  scs_state_type state_q;
  logic start_n_q;
  logic [8:0] cnt_q;
  logic [4:0] bit_q;
  logic [WIDTH-1:0] sar_q;
  logic [WIDTH-1:0] sar_d;
  logic [8:0] busy_cnt_q;
  logic over_q;
  logic under_q;
  logic load_q;
  logic tc_sel;
  logic fall;

  // one-hot weight of the bit under trial
  function automatic logic [WIDTH-1:0] weight(input logic [4:0] idx);
    weight = {{(WIDTH-1){1'b0}}, 1'b1} << idx;
  endfunction : weight

  assign fall = start_n_q && !i_conversion_start_n; // RULE_03
  // 18-bit parallel mode forces straight binary
  assign tc_sel = !i_output_coding_select &&
                  ({i_bus_mode_sel_hi, i_bus_mode_sel_lo} != `SCS_MODE_PAR18); // RULE_09 RULE_10

  ////////////////////////////////////////////////////////////////
  // strobe edge history
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      start_n_q <= 1'b1;
    end else if (i_ce) begin
      start_n_q <= i_conversion_start_n;
    end
  end

  ////////////////////////////////////////////////////////////////
  // phase sequencing; whole conversion is a fixed cycle count, no latency
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= SCS_ACQ;
      cnt_q <= '0;
      bit_q <= '0;
    end else if (i_ce) begin
      case (state_q)
        SCS_ACQ: begin
          cnt_q <= cnt_q + 9'h001;
          if (cnt_q >= 9'(ACQ_CYC - 1)) begin
            state_q <= SCS_READY;
          end
        end
        SCS_READY: begin
          // an edge during acquisition is not honoured
          if (fall) begin // RULE_02
            state_q <= SCS_HOLD;
            cnt_q <= '0;
          end
        end
        SCS_HOLD: begin
          cnt_q <= cnt_q + 9'h001;
          if (cnt_q >= 9'(APERTURE_CYC - 1)) begin // RULE_03
            state_q <= SCS_GND;
          end
        end
        SCS_GND: begin
          state_q <= SCS_TRIAL; // RULE_04
          bit_q <= 5'(WIDTH - 1);
        end
        SCS_TRIAL: begin
          if (bit_q == 5'h00) begin
            state_q <= SCS_CODE; // RULE_06
          end else begin
            bit_q <= bit_q - 5'h01; // RULE_05
          end
        end
        SCS_CODE: begin
          state_q <= SCS_ACQ;
          cnt_q <= '0;
        end
        default: begin
          state_q <= SCS_ACQ;
          cnt_q <= '0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // next sar word: set trial bit, keep it if comparator says input above dac
  always_comb begin
    sar_d = sar_q;
    if (state_q == SCS_GND) begin
      sar_d = weight(5'(WIDTH - 1)); // RULE_05
    end else if (state_q == SCS_TRIAL) begin
      if (!i_comp_high) begin
        sar_d = (sar_q & ~weight(bit_q)) | ((bit_q != 5'h00) ? weight(bit_q - 5'h01) : '0); // RULE_05
      end else if (bit_q != 5'h00) begin
        sar_d = sar_q | weight(bit_q - 5'h01);
      end
    end
  end

  // sar and dac word load the same next value; a dac copied from sar would judge a stale word
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sar_q <= '0;
      o_dac_bits <= '0;
    end else if (i_ce) begin
      sar_q <= sar_d;
      o_dac_bits <= sar_d; // RULE_05
    end
  end

  ////////////////////////////////////////////////////////////////
  // range flags captured with the sample
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      over_q <= 1'b0;
      under_q <= 1'b0;
    end else if (i_ce && state_q == SCS_READY && fall) begin
      over_q <= i_over;
      under_q <= i_under;
    end
  end

  ////////////////////////////////////////////////////////////////
  // switch controls and busy, all registered
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sample_switch_pos <= 1'b1;
      o_sample_switch_neg <= 1'b1;
      o_array_to_input <= 1'b1;
      o_array_to_reference_ground <= 1'b0;
      o_busy <= 1'b0;
      load_q <= 1'b0;
    end else if (i_ce) begin
      load_q <= (state_q == SCS_TRIAL) && (bit_q == 5'h00);
      if (state_q == SCS_READY && fall) begin
        o_busy <= 1'b1;
      end else if (load_q) begin
        o_busy <= 1'b0; // RULE_06
      end
      if (state_q == SCS_HOLD && cnt_q >= 9'(APERTURE_CYC - 1)) begin
        o_sample_switch_pos <= 1'b0; // RULE_04
        o_sample_switch_neg <= 1'b0;
      end else if (state_q == SCS_GND) begin
        o_array_to_input <= 1'b0; // RULE_04
        o_array_to_reference_ground <= 1'b1;
      end else if (state_q == SCS_CODE) begin
        o_sample_switch_pos <= 1'b1; // RULE_01
        o_sample_switch_neg <= 1'b1;
        o_array_to_input <= 1'b1;
        o_array_to_reference_ground <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // coder loads final sar word in the cycle after the last trial
  scs_coder #(.WIDTH(WIDTH)) u_coder (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_load(load_q), // RULE_07
    .i_raw(sar_q),
    .i_over(over_q),
    .i_under(under_q),
    .i_tc_sel(tc_sel),
    .o_code(o_code)
  );

  ////////////////////////////////////////////////////////////////
  // busy length counter for the length check; a long repetition would be costly to unroll
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_cnt_q <= '0;
    end else if (i_ce) begin
      busy_cnt_q <= o_busy ? busy_cnt_q + 9'h001 : 9'h000;
    end
  end

  ////////////////////////////////////////////////////////////////
  // assertions
  property p_no_early_start;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && fall && state_q == SCS_ACQ) |=> !o_busy || $past(o_busy);
  endproperty
  a_no_early_start: assert property (p_no_early_start) else $error("busy rose during acquisition"); // RULE_02

  property p_busy_on_edge;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && fall && state_q == SCS_READY) |=> o_busy;
  endproperty
  a_busy_on_edge: assert property (p_busy_on_edge) else $error("busy not raised at start"); // RULE_02

  property p_hold_order;
    @(posedge i_mclk) disable iff (!i_rst_n)
    $rose(o_array_to_reference_ground) |-> !o_sample_switch_pos && !$past(o_sample_switch_pos);
  endproperty
  a_hold_order: assert property (p_hold_order) else $error("arrays grounded before switches opened"); // RULE_04

  property p_track;
    @(posedge i_mclk) disable iff (!i_rst_n)
    !o_busy |-> o_array_to_input && !o_array_to_reference_ground;
  endproperty
  a_track: assert property (p_track) else $error("arrays not tracking while idle"); // RULE_01

  property p_conv_len;
    @(posedge i_mclk) disable iff (!i_rst_n || !i_ce)
    $fell(o_busy) |-> (busy_cnt_q == 9'(APERTURE_CYC + WIDTH + 2)) &&
                      ((busy_cnt_q + 9'(ACQ_CYC + 1)) <= 9'(`SCS_CONV_BUDGET_CYC));
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong"); // RULE_08

  property p_code_before_busy;
    @(posedge i_mclk) disable iff (!i_rst_n)
    $fell(o_busy) |-> $past(load_q);
  endproperty
  a_code_before_busy: assert property (p_code_before_busy) else $error("busy fell without new code"); // RULE_06

  property p_over;
    @(posedge i_mclk) disable iff (!i_rst_n)
    ($fell(o_busy) && over_q) |-> (o_code == (tc_sel ? `SCS_CODE_TOP_TC : `SCS_CODE_TOP_SB));
  endproperty
  a_over: assert property (p_over) else $error("overrange not saturated"); // RULE_12

  property p_under;
    @(posedge i_mclk) disable iff (!i_rst_n)
    ($fell(o_busy) && under_q && !over_q) |-> (o_code == (tc_sel ? `SCS_CODE_BOT_TC : `SCS_CODE_BOT_SB));
  endproperty
  a_under: assert property (p_under) else $error("underrange not saturated"); // RULE_13

  property p_par_sb;
    @(posedge i_mclk) disable iff (!i_rst_n)
    ({i_bus_mode_sel_hi, i_bus_mode_sel_lo} == `SCS_MODE_PAR18) |-> !tc_sel;
  endproperty
  a_par_sb: assert property (p_par_sb) else $error("coding select active in parallel mode"); // RULE_10

  c_conv: cover property (@(posedge i_mclk) $fell(o_busy));
  c_over: cover property (@(posedge i_mclk) $fell(o_busy) && over_q);
  c_tc: cover property (@(posedge i_mclk) $fell(o_busy) && tc_sel);
endmodule : scs_sequencer
`default_nettype wire

// ### scs_analog_model.sv
// comparator model standing in for the held analog sample
`timescale 1ns/100ps
`default_nettype none
module scs_analog_model (
  input wire logic [17:0] i_dac_bits,
  input wire logic [17:0] i_level,
  output logic o_comp_high
);
  // keep the trial bit while the held level reaches the trial word
  always_comb begin
    o_comp_high = (i_level >= i_dac_bits);
  end
endmodule : scs_analog_model
`default_nettype wire

// ### tb.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/100ps
`default_nettype none
module tb;
  import scs_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic start_n = 1'b1;
  logic sel = 1'b1;
  logic m_hi = 1'b1;
  logic m_lo = 1'b1;
  logic over = 1'b0;
  logic under = 1'b0;
  logic [17:0] level = 18'h00000;
  logic comp, sw_p, sw_n, to_in, to_gnd, busy;
  logic [17:0] dac, code;
  int mismatches = 0;
  int compares = 0;
  ////////////////////////////////////////////////////////////
  // clock and reset
  initial begin
    forever #4 i_mclk = ~i_mclk;
  end
  scs_analog_model model_u (.i_dac_bits(dac), .i_level(level), .o_comp_high(comp));
  scs_sequencer dut_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_conversion_start_n(start_n),
    .i_output_coding_select(sel), .i_bus_mode_sel_hi(m_hi), .i_bus_mode_sel_lo(m_lo), .i_comp_high(comp),
    .i_over(over), .i_under(under), .o_sample_switch_pos(sw_p), .o_sample_switch_neg(sw_n),
    .o_array_to_input(to_in), .o_array_to_reference_ground(to_gnd), .o_dac_bits(dac), .o_busy(busy),
    .o_code(code));
  ////////////////////////////////////////////////////////////
  task automatic finish_test;
    if (mismatches == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk
  // one conversion; glitch toggles the start strobe while busy
  task automatic convert(input logic [17:0] lvl, input logic cs, hi, lo, ov, un, gl, input logic [17:0] exp);
    level = lvl;
    sel = cs;
    m_hi = hi;
    m_lo = lo;
    over = ov;
    under = un;
    @(posedge i_mclk);
    #1 start_n = 1'b0;
    repeat (4) @(posedge i_mclk);
    #1 chk(busy === 1'b1 && to_gnd === 1'b1 && to_in === 1'b0, "conversion phase");
    chk(sw_p === 1'b0 && sw_n === 1'b0, "switches open");
    chk(dac === {lvl[17], 1'b1, 16'h0000}, "msb trial word");
    if (gl) begin
      start_n = 1'b1;
      @(posedge i_mclk);
      #1 start_n = 1'b0;
      repeat (16) @(posedge i_mclk);
    end else begin
      repeat (17) @(posedge i_mclk);
    end
    #1 chk(busy === 1'b1, "busy early fall");
    @(posedge i_mclk);
    #1 chk(busy === 1'b0, "busy stuck");
    chk(code === exp, "result code");
    start_n = 1'b1;
    repeat (4) @(posedge i_mclk);
    #1 chk(to_in === 1'b1 && sw_p === 1'b1 && sw_n === 1'b1, "tracking");
    repeat (46) @(posedge i_mclk);
    #1 chk(busy === 1'b0 && code === exp, "code stands");
  endtask : convert
  ////////////////////////////////////////////////////////////
  task automatic t_midscale;
    convert(18'h20000, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 18'h20000);
    convert(18'h20000, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 18'h00000);
  endtask : t_midscale
  task automatic t_values;
    convert(18'h2a5c3, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 18'h2a5c3);
    convert(18'h15a3c, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 18'h35a3c);
    convert(18'h00001, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 18'h00001);
  endtask : t_values
  task automatic t_range;
    convert(18'h3ffff, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 18'h3ffff);
    convert(18'h20000, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 18'h1ffff);
    convert(18'h20000, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 18'h00000);
    convert(18'h00000, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 18'h20000);
  endtask : t_range
  task automatic t_parallel;
    convert(18'h0f0f0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 18'h0f0f0);
    convert(18'h3ffff, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 18'h3ffff);
  endtask : t_parallel
  task automatic t_refused;
    convert(18'h12345, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 18'h12345);
  endtask : t_refused
  ////////////////////////////////////////////////////////////
  // main sequence; early edge during acquisition must be ignored
  initial begin
    repeat (5) @(posedge i_mclk);
    #1 i_rst_n = 1'b1;
    repeat (5) @(posedge i_mclk);
    #1 start_n = 1'b0;
    repeat (3) @(posedge i_mclk);
    #1 chk(busy === 1'b0, "start during acquisition");
    start_n = 1'b1;
    repeat (50) @(posedge i_mclk);
    t_midscale();
    t_values();
    t_range();
    t_parallel();
    t_refused();
    finish_test();
  end
  // watchdog: 5000 cycles, over five times the 12 conversions of 73 cycles each
  initial begin
    #40000;
    mismatches++;
    finish_test();
  end
endmodule : tb
`default_nettype wire
